// *** common/clkmgmt_pkg.sv ***
// constants for the serial clock management block: register map, fields, encodings
// assumes a single 200 MHz system clock and an AHB-Lite register port
// Contract
// RULE1: a 12-bit divide value up to 4095 divides the system clock by up to 8190
// RULE2: a divide value of zero leaves the divider idle with no divided clock
// RULE3: each high and low phase lasts exactly divide-value system clock periods
// RULE4: the one divided clock is offered to both transmitter and receiver
// RULE5: transmit clock comes from its pin, the receive clock or the divider
// RULE6: receive clock comes from its pin, the transmit clock or the divider
// RULE7: transmit clock is inverted internally when its invert bit is set
// RULE8: receive clock is inverted internally when its invert bit is set
// RULE9: inversion never changes the clock driven onto either clock pin
// RULE10: transmit clock pin is released, driven always, or driven during transfers
// RULE11: receive clock pin is released, driven always, or driven during transfers
// RULE12: software must not pick own pin as source with continuous pin output
// RULE13: external receive clock at most system/2 (sync input) or system/3 (output)
// RULE14: external transmit clock at most system/6 (sync input) or system/2 (output)
// RULE15: directions run alone, or share a clock and start together in lockstep
// RULE16: interrupt is high while any pending source is unmasked; status readable
// RULE17: software assigns the serial pins to this block before use
// RULE18: software enables this block's clock in the power management unit first
// RULE19: clock pin inputs are synchronised and edge detected in the system domain
package clkmgmt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DIV_W         = 12;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned EV_W          = 4;

  // register byte offsets
  localparam logic [7:0] OFF_DIVIDER   = 8'h00;
  localparam logic [7:0] OFF_TX_MODE   = 8'h04;
  localparam logic [7:0] OFF_RX_MODE   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  localparam logic [7:0] OFF_MASK      = 8'h10;
  localparam logic [7:0] OFF_CLK_STATE = 8'h14;

  // clock mode register fields
  localparam int unsigned SRC_LSB  = 0;
  localparam int unsigned OUT_LSB  = 2;
  localparam int unsigned INV_BIT  = 5;
  localparam int unsigned LOCK_BIT = 8;

  // clock source select encodings
  localparam logic [1:0] SRC_PIN   = 2'h0;
  localparam logic [1:0] SRC_OTHER = 2'h1;
  localparam logic [1:0] SRC_DIV   = 2'h2;

  // clock output mode encodings
  localparam logic [1:0] OUT_NONE  = 2'h0;
  localparam logic [1:0] OUT_CONT  = 2'h1;
  localparam logic [1:0] OUT_XFER  = 2'h2;

  // status and mask bits
  localparam int unsigned EV_TX_START    = 0;
  localparam int unsigned EV_RX_START    = 1;
  localparam int unsigned EV_TX_CONFLICT = 2;
  localparam int unsigned EV_RX_CONFLICT = 3;

  // clock state bits
  localparam int unsigned ST_TX_CLK  = 0;
  localparam int unsigned ST_RX_CLK  = 1;
  localparam int unsigned ST_DIV_CLK = 2;

  // reset values
  localparam logic [DIV_W-1:0] DIV_RST  = 12'h000;
  localparam logic [1:0]       SRC_RST  = 2'h0;
  localparam logic [1:0]       OUT_RST  = 2'h0;
  localparam logic [EV_W-1:0]  EV_RST   = 4'h0;

  // bus encodings
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;
endpackage

// *** hw/clk_divider.sv ***
// divider that turns the system clock into a 50% duty bit clock level
// assumes divide value comes from a register on the same clock
`timescale 1ns/1ps
module clk_divider
  import clkmgmt_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  div_clk_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             lvl;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  ////////////////////////////////////////////////////////////////////
  // phase counter, toggles after div_i cycles
  always_comb begin
    next_s = s;
    if (div_i == DIV_RST) begin
      next_s.cnt = DIV_RST; // RULE2
      next_s.lvl = 1'b0; // RULE2
    end else if (s.cnt >= div_i - 12'h001) begin
      next_s.cnt = DIV_RST; // RULE1
      next_s.lvl = ~s.lvl; // RULE3
    end else begin
      next_s.cnt = s.cnt + 12'h001;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div_clk_o = s.lvl;
endmodule // clk_divider

// *** hw/clk_path.sv ***
// one direction's clock path: source select, inversion, edges, pin drive
// assumes pin_i is asynchronous, other inputs come from clk_i logic
`timescale 1ns/1ps
module clk_path
  import clkmgmt_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pin_i,
  input  wire logic       other_clk_i,
  input  wire logic       div_clk_i,
  input  wire logic [1:0] src_i,
  input  wire logic       inv_i,
  input  wire logic [1:0] out_mode_i,
  input  wire logic       xfer_i,
  output logic            sel_clk_o,
  output logic            clk_o,
  output logic            rise_o,
  output logic            fall_o,
  output logic            pin_o,
  output logic            pin_oe_o,
  output logic            conflict_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sel;
    logic clk;
    logic rise;
    logic fall;
    logic pin_out;
    logic pin_oe;
    logic conflict;
  } path_state_t;

  path_state_t s;
  path_state_t next_s;

  ////////////////////////////////////////////////////////////////////
  // select, invert, detect edges, drive pin
  always_comb begin
    next_s = s;
    next_s.sync1 = pin_i; // RULE19
    next_s.sync2 = s.sync1; // RULE19
    case (src_i)
      SRC_PIN:   next_s.sel = s.sync2; // RULE5 RULE6
      SRC_OTHER: next_s.sel = other_clk_i; // RULE15
      SRC_DIV:   next_s.sel = div_clk_i; // RULE4
      default:   next_s.sel = 1'b0;
    endcase
    next_s.clk  = next_s.sel ^ inv_i; // RULE7 RULE8
    next_s.rise = next_s.clk & ~s.clk; // RULE19
    next_s.fall = ~next_s.clk & s.clk; // RULE19
    case (out_mode_i)
      OUT_CONT: next_s.pin_oe = 1'b1; // RULE10 RULE11
      OUT_XFER: next_s.pin_oe = xfer_i; // RULE10 RULE11
      default:  next_s.pin_oe = 1'b0;
    endcase
    // pin carries the uninverted clock
    next_s.pin_out  = next_s.pin_oe & next_s.sel; // RULE9
    next_s.conflict = (src_i == SRC_PIN) && (out_mode_i == OUT_CONT); // RULE12
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sel_clk_o  = s.sel;
  assign clk_o      = s.clk;
  assign rise_o     = s.rise;
  assign fall_o     = s.fall;
  assign pin_o      = s.pin_out;
  assign pin_oe_o   = s.pin_oe;
  assign conflict_o = s.conflict;
endmodule // clk_path

// *** hw/clock_mgmt_top.sv ***
// serial controller clock management with AHB-Lite registers and interrupt
// assumes one system clock, synchronous reset, pins already muxed to this block
`timescale 1ns/1ps
module clock_mgmt_top
  import clkmgmt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // clock pins
  input  wire logic        tx_clock_pin_i,
  output logic             tx_clock_pin_o,
  output logic             tx_clock_pin_oe_o,
  input  wire logic        rx_clock_pin_i,
  output logic             rx_clock_pin_o,
  output logic             rx_clock_pin_oe_o,
  // transfer side
  input  wire logic        tx_xfer_i,
  input  wire logic        rx_xfer_i,
  input  wire logic        tx_start_req_i,
  input  wire logic        rx_start_req_i,
  output logic             tx_start_o,
  output logic             rx_start_o,
  output logic             tx_clk_o,
  output logic             tx_clk_rise_o,
  output logic             tx_clk_fall_o,
  output logic             rx_clk_o,
  output logic             rx_clk_rise_o,
  output logic             rx_clk_fall_o,
  output logic             irq_o
);
  typedef struct packed {
    logic [DIV_W-1:0]  div_val;
    logic [1:0]        tx_src;
    logic [1:0]        tx_out;
    logic              tx_inv;
    logic              tx_lock;
    logic [1:0]        rx_src;
    logic [1:0]        rx_out;
    logic              rx_inv;
    logic              rx_lock;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              wr_pend;
    logic              rd_pend;
    logic [ADDR_W-1:0] addr_q;
    logic [31:0]       rdata;
    logic              ready;
    logic              irq;
    logic              tx_start;
    logic              rx_start;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic            div_clk;
  logic            tx_sel_clk;
  logic            rx_sel_clk;
  logic            tx_clk_lvl;
  logic            rx_clk_lvl;
  logic            tx_conflict;
  logic            rx_conflict;
  logic            accept;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clear;
  logic [31:0]     rd_mux;

  ////////////////////////////////////////////////////////////////////
  // shared divider
  clk_divider u_div (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .div_i     (s.div_val),
    .div_clk_o (div_clk)
  );

  // transmit path, other clock is the registered receive selection
  clk_path u_tx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_i       (tx_clock_pin_i),
    .other_clk_i (rx_sel_clk),
    .div_clk_i   (div_clk),
    .src_i       (s.tx_src),
    .inv_i       (s.tx_inv),
    .out_mode_i  (s.tx_out),
    .xfer_i      (tx_xfer_i),
    .sel_clk_o   (tx_sel_clk),
    .clk_o       (tx_clk_lvl),
    .rise_o      (tx_clk_rise_o),
    .fall_o      (tx_clk_fall_o),
    .pin_o       (tx_clock_pin_o),
    .pin_oe_o    (tx_clock_pin_oe_o),
    .conflict_o  (tx_conflict)
  );

  // receive path, other clock is the registered transmit selection
  clk_path u_rx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .pin_i       (rx_clock_pin_i),
    .other_clk_i (tx_sel_clk),
    .div_clk_i   (div_clk),
    .src_i       (s.rx_src),
    .inv_i       (s.rx_inv),
    .out_mode_i  (s.rx_out),
    .xfer_i      (rx_xfer_i),
    .sel_clk_o   (rx_sel_clk),
    .clk_o       (rx_clk_lvl),
    .rise_o      (rx_clk_rise_o),
    .fall_o      (rx_clk_fall_o),
    .pin_o       (rx_clock_pin_o),
    .pin_oe_o    (rx_clock_pin_oe_o),
    .conflict_o  (rx_conflict)
  );

  assign tx_clk_o = tx_clk_lvl;
  assign rx_clk_o = rx_clk_lvl;

  ////////////////////////////////////////////////////////////////////
  // bus address phase accept
  assign accept = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;

  // event sources
  always_comb begin
    events = EV_RST;
    events[EV_TX_START]    = s.tx_start;
    events[EV_RX_START]    = s.rx_start;
    events[EV_TX_CONFLICT] = tx_conflict;
    events[EV_RX_CONFLICT] = rx_conflict;
  end

  // write-one-to-clear mask for the status register
  always_comb begin
    clear = EV_RST;
    if (s.wr_pend && s.addr_q == OFF_STATUS) begin
      clear = hwdata_i[EV_W-1:0];
    end
  end

  // read data mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (s.addr_q)
      OFF_DIVIDER: begin
        rd_mux[DIV_W-1:0] = s.div_val;
      end
      OFF_TX_MODE: begin
        rd_mux[SRC_LSB +: 2] = s.tx_src;
        rd_mux[OUT_LSB +: 2] = s.tx_out;
        rd_mux[INV_BIT]      = s.tx_inv;
        rd_mux[LOCK_BIT]     = s.tx_lock;
      end
      OFF_RX_MODE: begin
        rd_mux[SRC_LSB +: 2] = s.rx_src;
        rd_mux[OUT_LSB +: 2] = s.rx_out;
        rd_mux[INV_BIT]      = s.rx_inv;
        rd_mux[LOCK_BIT]     = s.rx_lock;
      end
      OFF_STATUS: begin
        rd_mux[EV_W-1:0] = s.status; // RULE16
      end
      OFF_MASK: begin
        rd_mux[EV_W-1:0] = s.mask;
      end
      OFF_CLK_STATE: begin
        rd_mux[ST_TX_CLK]  = tx_clk_lvl;
        rd_mux[ST_RX_CLK]  = rx_clk_lvl;
        rd_mux[ST_DIV_CLK] = div_clk;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state: bus, registers, status, interrupt, starts
  always_comb begin
    next_s = s;
    // address phase capture; a read adds one wait state
    next_s.wr_pend = accept & hwrite_i;
    next_s.rd_pend = accept & ~hwrite_i;
    if (accept) begin
      next_s.addr_q = haddr_i[ADDR_W-1:0];
    end
    next_s.ready = ~(accept & ~hwrite_i);
    if (s.rd_pend) begin
      next_s.rdata = rd_mux;
    end
    // register writes in the data phase
    if (s.wr_pend) begin
      case (s.addr_q)
        OFF_DIVIDER: begin
          next_s.div_val = hwdata_i[DIV_W-1:0]; // RULE1
        end
        OFF_TX_MODE: begin
          next_s.tx_src  = hwdata_i[SRC_LSB +: 2]; // RULE5
          next_s.tx_out  = hwdata_i[OUT_LSB +: 2]; // RULE10
          next_s.tx_inv  = hwdata_i[INV_BIT]; // RULE7
          next_s.tx_lock = hwdata_i[LOCK_BIT]; // RULE15
        end
        OFF_RX_MODE: begin
          next_s.rx_src  = hwdata_i[SRC_LSB +: 2]; // RULE6
          next_s.rx_out  = hwdata_i[OUT_LSB +: 2]; // RULE11
          next_s.rx_inv  = hwdata_i[INV_BIT]; // RULE8
          next_s.rx_lock = hwdata_i[LOCK_BIT]; // RULE15
        end
        OFF_MASK: begin
          next_s.mask = hwdata_i[EV_W-1:0]; // RULE16
        end
        default: begin
          next_s.mask = s.mask;
        end
      endcase
    end
    // sticky status, a new event beats a clear in the same cycle
    next_s.status = (s.status & ~clear) | events; // RULE16
    next_s.irq    = |(s.status & s.mask); // RULE16
    // lockstep start: follow the other direction's start when enabled
    next_s.tx_start = tx_start_req_i | (s.tx_lock & rx_start_req_i); // RULE15
    next_s.rx_start = rx_start_req_i | (s.rx_lock & tx_start_req_i); // RULE15
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.div_val <= DIV_RST;
      s.tx_src  <= SRC_RST;
      s.tx_out  <= OUT_RST;
      s.rx_src  <= SRC_RST;
      s.rx_out  <= OUT_RST;
      s.status  <= EV_RST;
      s.mask    <= EV_RST;
      s.ready   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // bus and interrupt outputs
  assign hrdata_o    = s.rdata;
  assign hreadyout_o = s.ready;
  assign hresp_o     = HRESP_OKAY;
  assign irq_o       = s.irq;
  assign tx_start_o  = s.tx_start;
  assign rx_start_o  = s.rx_start;
endmodule // clock_mgmt_top

// *** sim/codec_model.sv ***
// external codec making a slave-mode bit clock on one clock pin
// assumes the system clock for timing; the clock stands low outside frames
`timescale 1ns/1ps
module codec_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] half_i,
  output logic            pin_o
);
  logic [7:0] cnt;
  logic [7:0] lim;
  ////////////////////////////////////////////////////////////////////////////////
  // half period floored at 3 cycles, inside both pin ratio limits
  assign lim = (half_i < 8'h03) ? 8'h03 : half_i;
  // toggle every lim cycles, stand still low between frames
  always_ff @(posedge clk_i) begin
    if (!en_i) begin
      cnt   <= 8'h00;
      pin_o <= 1'h0;
    end else if (cnt == lim - 8'h01) begin
      cnt   <= 8'h00;
      pin_o <= ~pin_o;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // codec_model

// *** sim/clock_mgmt_sva.sv ***
// checker for clock_mgmt_top: bus wait states, clock edges, pin drive, starts
// assumes one system clock with synchronous active-high reset
`timescale 1ns/1ps
module clock_mgmt_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic       hready_i,
  input wire logic       hreadyout_o,
  input wire logic       tx_clock_pin_o,
  input wire logic       tx_clock_pin_oe_o,
  input wire logic       rx_clock_pin_o,
  input wire logic       rx_clock_pin_oe_o,
  input wire logic       tx_start_req_i,
  input wire logic       rx_start_req_i,
  input wire logic       tx_start_o,
  input wire logic       rx_start_o,
  input wire logic       tx_clk_o,
  input wire logic       tx_clk_rise_o,
  input wire logic       tx_clk_fall_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer timing
  AST_READ_WAIT: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
    |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i
    |=> hreadyout_o) else $error("write wait state seen");
  // released pins sit low
  AST_TX_PIN_IDLE: assert property (!tx_clock_pin_oe_o |-> !tx_clock_pin_o)
    else $error("tx pin not low while released");
  AST_RX_PIN_IDLE: assert property (!rx_clock_pin_oe_o |-> !rx_clock_pin_o)
    else $error("rx pin not low while released");
  // driven tx pin moves with every internal tx edge; tx rise pulse matches the level
  AST_TX_PIN_EDGE: assert property ((tx_clk_rise_o || tx_clk_fall_o)
    && tx_clock_pin_oe_o && $past(tx_clock_pin_oe_o) |-> tx_clock_pin_o != $past(tx_clock_pin_o))
    else $error("tx pin missed an edge");
  AST_TX_RISE: assert property (tx_clk_rise_o |-> tx_clk_o && !$past(tx_clk_o))
    else $error("tx rise pulse wrong");
  // start pulses
  AST_TX_START: assert property (tx_start_req_i |=> tx_start_o)
    else $error("tx start missing");
  AST_RX_START: assert property (rx_start_o
    |-> $past(rx_start_req_i) || $past(tx_start_req_i)) else $error("rx start uncaused");
endmodule // clock_mgmt_sva

bind clock_mgmt_top clock_mgmt_sva chk (
  .clk_i, .rst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o,
  .tx_clock_pin_o, .tx_clock_pin_oe_o, .rx_clock_pin_o, .rx_clock_pin_oe_o,
  .tx_start_req_i, .rx_start_req_i, .tx_start_o, .rx_start_o,
  .tx_clk_o, .tx_clk_rise_o, .tx_clk_fall_o
);

// *** sim/tb_top.sv ***
// self-checking bench for clock_mgmt_top with a codec model on each clock pin
// assumes the package, design, codec model and bound checker are compiled first
`timescale 1ns/1ps
module tb_top;
  import clkmgmt_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        hsel_i = 1'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rd;
  logic        hreadyout_o, hresp_o, irq_o, tx_en = 1'h0, rx_en = 1'h0;
  logic        tx_xfer_i = 1'h0, rx_xfer_i = 1'h0, tx_start_req_i = 1'h0, rx_start_req_i = 1'h0;
  logic        tx_clock_pin_o, tx_clock_pin_oe_o, rx_clock_pin_o, rx_clock_pin_oe_o;
  logic        tx_start_o, rx_start_o, tx_clk_o, tx_clk_rise_o, tx_clk_fall_o;
  logic        rx_clk_o, rx_clk_rise_o, rx_clk_fall_o, tx_mdl, rx_mdl, tx_wire, rx_wire;
  int          n_fail = 0, tests_run = 0, cycles = 0;
  // wire level from the design's enable and the codec
  assign tx_wire = tx_clock_pin_oe_o ? tx_clock_pin_o : tx_mdl;
  assign rx_wire = rx_clock_pin_oe_o ? rx_clock_pin_o : rx_mdl;
  clock_mgmt_top DUT (
    .clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .tx_clock_pin_i(tx_wire), .tx_clock_pin_o, .tx_clock_pin_oe_o,
    .rx_clock_pin_i(rx_wire), .rx_clock_pin_o, .rx_clock_pin_oe_o,
    .tx_xfer_i, .rx_xfer_i, .tx_start_req_i, .rx_start_req_i, .tx_start_o, .rx_start_o,
    .tx_clk_o, .tx_clk_rise_o, .tx_clk_fall_o, .rx_clk_o, .rx_clk_rise_o, .rx_clk_fall_o,
    .irq_o
  );
  codec_model tx_codec (.clk_i, .en_i(tx_en), .half_i(8'h05), .pin_o(tx_mdl));
  codec_model rx_codec (.clk_i, .en_i(rx_en), .half_i(8'h04), .pin_o(rx_mdl));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i   <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'h1);
    hsel_i   <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'h1);
    rd = hrdata_o;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    chk(nm, exp, rd);
    chk("response", {31'h0, HRESP_OKAY}, {31'h0, hresp_o});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [31:0] md(logic [1:0] s, logic [1:0] o, logic i);
    return {26'h0, i, 1'h0, o, s};
  endfunction
  task automatic setm(input logic [31:0] t, input logic [31:0] r);
    ahb(1'h1, OFF_TX_MODE, t);
    ahb(1'h1, OFF_RX_MODE, r);
    cyc(8);
    @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic s_regs();
    for (int i = 0; i < 6; i++) rdc("reset value", 8'(4 * i), 32'h0);
    ahb(1'h1, OFF_DIVIDER, 32'hFFFF_FFFF);
    rdc("divider width", OFF_DIVIDER, 32'h0000_0FFF);
    ahb(1'h1, 8'h20, 32'h5A5A_5A5A);
    rdc("unmapped", 8'h20, 32'h0);
    ahb(1'h1, OFF_DIVIDER, 32'h0);
  endtask
  task automatic s_div();
    int unsigned vals [4] = '{1, 2, 7, 4095};
    int unsigned n;
    setm(md(SRC_DIV, OUT_NONE, 1'h0), md(SRC_DIV, OUT_NONE, 1'h0));
    chk("divider idle", 32'h0, {31'h0, tx_clk_o});
    foreach (vals[i]) begin
      ahb(1'h1, OFF_DIVIDER, vals[i]);
      // skip edges still timed by the old divide value
      cyc(2);
      do @(negedge clk_i); while (tx_clk_rise_o !== 1'h1);
      for (int ph = 0; ph < 2; ph++) begin
        n = 0;
        do begin
          @(negedge clk_i);
          n++;
        end while ((ph == 0 ? tx_clk_fall_o : tx_clk_rise_o) !== 1'h1);
        chk("half period", vals[i], n);
        chk("rx edges", {30'h0, tx_clk_rise_o, tx_clk_fall_o},
            {30'h0, rx_clk_rise_o, rx_clk_fall_o});
      end
      chk("shared clock", {31'h0, tx_clk_o}, {31'h0, rx_clk_o});
    end
    ahb(1'h1, OFF_DIVIDER, 32'h2);
    setm(md(SRC_DIV, OUT_NONE, 1'h0), md(SRC_DIV, OUT_NONE, 1'h1));
    chk("rx inverted", {31'h0, ~tx_clk_o}, {31'h0, rx_clk_o});
    setm(md(SRC_DIV, OUT_NONE, 1'h1), md(SRC_DIV, OUT_NONE, 1'h0));
    chk("tx inverted", {31'h0, ~rx_clk_o}, {31'h0, tx_clk_o});
    setm(md(SRC_DIV, OUT_NONE, 1'h0), md(SRC_DIV, OUT_NONE, 1'h0));
    ahb(1'h1, OFF_DIVIDER, 32'h0);
    ahb(1'h1, OFF_CLK_STATE, 32'h7);
    cyc(8);
    rdc("clock state", OFF_CLK_STATE, 32'h0);
  endtask
  task automatic s_pin();
    logic [3:0] h;
    logic       pv;
    @(posedge clk_i);
    tx_en <= 1'h1;
    rx_en <= 1'h1;
    for (int p = 0; p < 2; p++) begin
      if (p == 0)
        setm(md(SRC_PIN, OUT_NONE, 1'h0), md(SRC_OTHER, OUT_NONE, 1'h0));
      else
        setm(md(SRC_OTHER, OUT_NONE, 1'h0), md(SRC_PIN, OUT_NONE, 1'h0));
      for (int i = 0; i < 40; i++) begin
        @(negedge clk_i);
        h = {h[2:0], (p == 0 ? tx_wire : rx_wire)};
        if (i > 3) begin
          chk("pin clock", {31'h0, h[3]}, {31'h0, (p == 0 ? tx_clk_o : rx_clk_o)});
          chk("other clock", {31'h0, pv}, {31'h0, (p == 0 ? rx_clk_o : tx_clk_o)});
        end
        pv = (p == 0) ? tx_clk_o : rx_clk_o;
      end
    end
    setm(md(2'h3, OUT_NONE, 1'h0), md(2'h3, OUT_NONE, 1'h0));
    chk("source off", 32'h0, {30'h0, tx_clk_o, rx_clk_o});
    tx_en <= 1'h0;
    rx_en <= 1'h0;
  endtask
  task automatic pins(input logic inv);
    repeat (12) begin
      @(negedge clk_i);
      chk("pin enable", 32'h3, {30'h0, tx_clock_pin_oe_o, rx_clock_pin_oe_o});
      chk("pin level", {30'h0, tx_clk_o ^ inv, rx_clk_o ^ inv},
          {30'h0, tx_clock_pin_o, rx_clock_pin_o});
    end
  endtask
  task automatic s_out();
    ahb(1'h1, OFF_DIVIDER, 32'h3);
    setm(md(SRC_DIV, OUT_NONE, 1'h0), md(SRC_DIV, OUT_NONE, 1'h0));
    chk("released", 32'h0, {30'h0, tx_clock_pin_oe_o, rx_clock_pin_oe_o});
    setm(md(SRC_DIV, OUT_CONT, 1'h0), md(SRC_DIV, OUT_CONT, 1'h0));
    pins(1'h0);
    setm(md(SRC_DIV, OUT_XFER, 1'h0), md(SRC_DIV, OUT_XFER, 1'h0));
    chk("no transfer", 32'h0, {30'h0, tx_clock_pin_oe_o, rx_clock_pin_oe_o});
    @(posedge clk_i);
    tx_xfer_i <= 1'h1;
    rx_xfer_i <= 1'h1;
    cyc(4);
    pins(1'h0);
    @(posedge clk_i);
    tx_xfer_i <= 1'h0;
    rx_xfer_i <= 1'h0;
    cyc(4);
    setm(md(SRC_DIV, OUT_CONT, 1'h1), md(SRC_DIV, OUT_CONT, 1'h1));
    pins(1'h1);
    setm(32'h0, 32'h0);
  endtask
  task automatic start(input logic t, input logic r, input logic [1:0] exp);
    @(posedge clk_i);
    tx_start_req_i <= t;
    rx_start_req_i <= r;
    @(posedge clk_i);
    tx_start_req_i <= 1'h0;
    rx_start_req_i <= 1'h0;
    @(negedge clk_i);
    chk("start pulse", {30'h0, exp}, {30'h0, tx_start_o, rx_start_o});
  endtask
  task automatic s_irq();
    start(1'h1, 1'h0, 2'h2);
    rdc("status", OFF_STATUS, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    ahb(1'h1, OFF_MASK, 32'h1);
    cyc(2);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    ahb(1'h1, OFF_STATUS, 32'h1);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    ahb(1'h1, OFF_RX_MODE, 32'h100);
    start(1'h1, 1'h0, 2'h3);
    start(1'h0, 1'h1, 2'h1);
    rdc("both starts", OFF_STATUS, 32'h3);
    ahb(1'h1, OFF_STATUS, 32'h3);
    ahb(1'h1, OFF_TX_MODE, md(SRC_PIN, OUT_CONT, 1'h0));
    cyc(4);
    rdc("conflict", OFF_STATUS, 32'h4);
    ahb(1'h1, OFF_MASK, 32'h4);
    cyc(2);
    chk("conflict irq", 32'h1, {31'h0, irq_o});
    ahb(1'h1, OFF_TX_MODE, 32'h0);
    ahb(1'h1, OFF_STATUS, 32'h4);
    rdc("status clear", OFF_STATUS, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    s_regs();
    s_div();
    s_pin();
    s_out();
    s_irq();
    complete_run();
  end
endmodule // tb_top
